/* hdl/ssrx_defines.vh */
`ifndef SSRX_DEFINES_VH
`define SSRX_DEFINES_VH
// register byte addresses
`define SSRX_A_CSR 8'h00
`define SSRX_A_RXCTRL 8'h04
`define SSRX_A_CTRL2 8'h08
`define SSRX_A_OPTION 8'h0C
`define SSRX_A_RXDATA 8'h10
`define SSRX_A_TXDATA 8'h14
// ctrl_reg_two fields
`define SSRX_C2_PORT_ON 0
`define SSRX_C2_RX_ON 1
`define SSRX_C2_TX_ON 2
`define SSRX_C2_GATED 3
`define SSRX_C2_MASTER 4
`define SSRX_C2_NETWORK 5
// option_reg fields
`define SSRX_OP_FIFO_ON 0
`define SSRX_OP_IRQ_ON 1
`define SSRX_OP_WM_LSB 4
// rx_ctrl_reg fields
`define SSRX_RC_WL_LSB 0
`define SSRX_RC_DC_LSB 2
// ctrl_status_reg fields
`define SSRX_CS_READY 0
`define SSRX_CS_FULL 1
`define SSRX_CS_OVR 2
`define SSRX_CS_RUN 3
`define SSRX_CS_LVL_LSB 8
// reset values
`define SSRX_RST_CTRL2 6'h00
`define SSRX_RST_OPTION 8'h00
`define SSRX_RST_RXCTRL 7'h00
// internal bit clock half period in port clocks
`define SSRX_HALF_DIV 8'h02
`endif

/* hdl/ssrx_sync3.v */
`timescale 1ns/1ps
// three-stage synchroniser; level changes once stages two and three agree
module ssrx_sync3 (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire din,
  output reg lvl_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
endmodule

/* hdl/ssrx_queue.v */
`timescale 1ns/1ps
// receive queue, refuses a push when full
module ssrx_queue #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg [AW:0] level_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (level_q != DEPTH[AW:0]);
  assign out_valid = (level_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];

  always @(posedge clock) begin
    if (ce && push) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wp_q <= {AW{1'b0}};
        rp_q <= {AW{1'b0}};
        level_q <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
        end
        if (pop) begin
          rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
        end
        if (push && !pop) begin
          level_q <= level_q + 1'b1;
        end else if (pop && !push) begin
          level_q <= level_q - 1'b1;
        end
      end
    end
  end
endmodule

/* hdl/ssrx_port.v */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ssrx_defines.vh"
module ssrx_port #(
  parameter QDEPTH = 8,
  parameter QAW = 3
) (
  input wire clock,
  input wire arst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_clock_pin,
  input wire rx_frame_sync_pin,
  input wire rx_data_pin,
  input wire tx_clock_pin_in,
  output wire tx_clock_pin_out,
  output wire tx_clock_pin_oe,
  output wire tx_data_pin_out,
  output wire tx_data_pin_oe,
  output wire rx_irq
);
  function [4:0] wl_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: wl_decode = 5'h08;
        2'h1: wl_decode = 5'h0A;
        2'h2: wl_decode = 5'h0C;
        default: wl_decode = 5'h10;
      endcase
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `SSRX_A_CSR) || (a == `SSRX_A_RXCTRL) || (a == `SSRX_A_CTRL2) ||
        (a == `SSRX_A_OPTION) || (a == `SSRX_A_RXDATA) || (a == `SSRX_A_TXDATA);
    end
  endfunction

  reg [5:0] ctrl2_q;
  reg [7:0] option_q;
  reg [6:0] rxctrl_q;
  reg [15:0] rx_data_q;
  reg [15:0] rx_sh_q;
  reg [15:0] tx_data_q;
  reg [15:0] tx_sh_q;
  reg ready_q;
  reg ovr_q;
  reg arm_q;
  reg run_q;
  reg [8:0] fbit_q;
  reg rxclk_d1_q;
  reg fs_d1_q;
  reg txclk_d1_q;
  reg [7:0] div_q;
  reg iclk_q;
  reg [4:0] ibit_q;
  reg [4:0] islot_q;
  reg tx_pend_q;
  reg tx_busy_q;
  reg [4:0] tbit_q;
  wire rxclk_s;
  wire fs_s;
  wire rxd_s;
  wire txclk_s;
  wire [QAW:0] q_level;
  wire q_in_ready;
  wire q_out_valid;
  wire [15:0] q_out_data;

  wire port_on = ctrl2_q[`SSRX_C2_PORT_ON];
  wire rx_on = ctrl2_q[`SSRX_C2_RX_ON];
  wire tx_on = ctrl2_q[`SSRX_C2_TX_ON];
  wire master = ctrl2_q[`SSRX_C2_MASTER];
  wire gated = ctrl2_q[`SSRX_C2_GATED] & ~ctrl2_q[`SSRX_C2_NETWORK];
  wire fifo_on = option_q[`SSRX_OP_FIFO_ON];
  wire irq_on = option_q[`SSRX_OP_IRQ_ON];
  wire [3:0] wmark = option_q[`SSRX_OP_WM_LSB +: 4];
  wire [4:0] wl = wl_decode(rxctrl_q[`SSRX_RC_WL_LSB +: 2]);
  wire [4:0] dc = rxctrl_q[`SSRX_RC_DC_LSB +: 5];
  wire [8:0] wl9 = {4'h0, wl};
  // frame spans word_bits times (slot_count + 1) bit clocks; saturates at counter top
  wire [9:0] flen_full = {5'h00, wl} * ({5'h00, dc} + 10'h001);
  wire [8:0] frame_len = flen_full[9] ? 9'h1FF : flen_full[8:0];

  // APB: zero wait states, read data captured in the setup cycle
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite & addr_ok(paddr);
  wire rd_data = acc & ~pwrite & (paddr == `SSRX_A_RXDATA);
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok(paddr);

  ssrx_sync3 u_sync_rxclk (.clock(clock), .arst_n(arst_n), .ce(ce), .din(rx_clock_pin),
    .lvl_q(rxclk_s));
  ssrx_sync3 u_sync_fs (.clock(clock), .arst_n(arst_n), .ce(ce), .din(rx_frame_sync_pin),
    .lvl_q(fs_s));
  ssrx_sync3 u_sync_rxd (.clock(clock), .arst_n(arst_n), .ce(ce), .din(rx_data_pin),
    .lvl_q(rxd_s));
  ssrx_sync3 u_sync_txclk (.clock(clock), .arst_n(arst_n), .ce(ce), .din(tx_clock_pin_in),
    .lvl_q(txclk_s));

  wire rxclk_fall = rxclk_d1_q & ~rxclk_s;
  wire fs_rise = fs_s & ~fs_d1_q;
  wire txclk_fall = txclk_d1_q & ~txclk_s;
  wire tick = (div_q == `SSRX_HALF_DIV - 8'h01);
  wire int_fall = port_on & tick & iclk_q;
  wire word_edge = int_fall & (ibit_q == wl - 5'h01);

  // gated receive-only needs an outside clock
  wire gated_ok = gated & (tx_on | ~master);
  // gated mode takes its clock from the transmit clock pin as slave, from the internal bit clock as master
  wire g_fall = master ? (int_fall & tx_busy_q) : txclk_fall;
  wire rx_fall = gated ? g_fall : rxclk_fall;
  wire in_slot0 = gated | (fbit_q < wl9);
  wire rx_take = port_on & run_q & rx_fall & in_slot0;
  wire [15:0] rx_word = (fbit_q == 9'h000) ? {15'h0000, rxd_s} : {rx_sh_q[14:0], rxd_s};
  // load coincides with the capture of the final bit, mid last bit
  wire deliver = rx_take & (fbit_q == wl9 - 9'h001);
  wire q_push = deliver & fifo_on;
  wire q_pop = rd_data & fifo_on;
  wire full_flag = fifo_on & (q_level > {1'b0, wmark});
  wire ovr_evt = deliver & (fifo_on ? ~q_in_ready : (ready_q & ~rd_data));

  assign rx_irq = irq_on & (fifo_on ? full_flag : ready_q);
  assign tx_clock_pin_out = tx_busy_q & iclk_q;
  assign tx_clock_pin_oe = port_on & gated & master;
  // word kept left-aligned so the pin comes straight from a flop
  assign tx_data_pin_out = tx_sh_q[15];
  assign tx_data_pin_oe = port_on & gated & tx_on;

  ssrx_queue #(.WIDTH(16), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .flush(~port_on | ~fifo_on),
    .in_valid(q_push),
    .in_ready(q_in_ready),
    .in_data(rx_word),
    .out_valid(q_out_valid),
    .out_ready(q_pop),
    .out_data(q_out_data),
    .level_q(q_level)
  );

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl2_q <= `SSRX_RST_CTRL2;
      option_q <= `SSRX_RST_OPTION;
      rxctrl_q <= `SSRX_RST_RXCTRL;
      prdata <= 32'h00000000;
      tx_data_q <= 16'h0000;
    end else if (ce) begin
      if (wr && paddr == `SSRX_A_CTRL2) begin
        ctrl2_q <= pwdata[5:0];
      end
      if (wr && paddr == `SSRX_A_OPTION) begin
        option_q <= pwdata[7:0];
      end
      if (wr && paddr == `SSRX_A_RXCTRL) begin
        rxctrl_q <= pwdata[6:0];
      end
      if (wr && paddr == `SSRX_A_TXDATA) begin
        tx_data_q <= pwdata[15:0];
      end
      if (setup) begin
        case (paddr)
          `SSRX_A_CSR: prdata <= {{(23-QAW){1'b0}}, q_level, 4'h0, run_q, ovr_q, full_flag,
            ready_q};
          `SSRX_A_RXCTRL: prdata <= {25'h0000000, rxctrl_q};
          `SSRX_A_CTRL2: prdata <= {26'h0000000, ctrl2_q};
          `SSRX_A_OPTION: prdata <= {24'h000000, option_q};
          `SSRX_A_RXDATA: prdata <= {16'h0000, fifo_on ? (q_out_valid ? q_out_data : 16'h0000)
            : rx_data_q};
          `SSRX_A_TXDATA: prdata <= {16'h0000, tx_data_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // receive sequencing, flags and data register
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxclk_d1_q <= 1'b0;
      fs_d1_q <= 1'b0;
      txclk_d1_q <= 1'b0;
      arm_q <= 1'b0;
      run_q <= 1'b0;
      fbit_q <= 9'h000;
      rx_sh_q <= 16'h0000;
      rx_data_q <= 16'h0000;
      ready_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (ce) begin
      rxclk_d1_q <= rxclk_s;
      fs_d1_q <= fs_s;
      txclk_d1_q <= txclk_s;
      if (!port_on || !rx_on) begin
        arm_q <= 1'b0;
        run_q <= 1'b0;
        fbit_q <= 9'h000;
      end else if (gated) begin
        arm_q <= 1'b0;
        run_q <= gated_ok;
        if (!gated_ok) begin
          fbit_q <= 9'h000;
        end else if (rx_take) begin
          fbit_q <= deliver ? 9'h000 : fbit_q + 9'h001;
        end
      end else begin
        if (!run_q && !arm_q) begin
          arm_q <= 1'b1;
        end
        if (fs_rise && (arm_q || run_q)) begin
          run_q <= 1'b1;
          arm_q <= 1'b0;
          fbit_q <= 9'h000;
        end else if (run_q && rx_fall && fbit_q < frame_len) begin
          fbit_q <= fbit_q + 9'h001;
        end
      end
      if (rx_take) begin
        rx_sh_q <= rx_word;
      end
      if (deliver && !fifo_on) begin
        rx_data_q <= rx_word;
      end
      if (deliver && !fifo_on) begin
        ready_q <= 1'b1;
      end else if (rd_data || fifo_on) begin
        ready_q <= 1'b0;
      end
      if (ovr_evt) begin
        ovr_q <= 1'b1;
      end else if (wr && paddr == `SSRX_A_CSR && pwdata[`SSRX_CS_OVR]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // internal bit, word and frame clocks run whenever the port is on
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 8'h00;
      iclk_q <= 1'b0;
      ibit_q <= 5'h00;
      islot_q <= 5'h00;
    end else if (ce) begin
      if (!port_on) begin
        div_q <= 8'h00;
        iclk_q <= 1'b0;
        ibit_q <= 5'h00;
        islot_q <= 5'h00;
      end else begin
        div_q <= tick ? 8'h00 : div_q + 8'h01;
        if (tick) begin
          iclk_q <= ~iclk_q;
        end
        if (int_fall) begin
          ibit_q <= word_edge ? 5'h00 : ibit_q + 5'h01;
          if (word_edge) begin
            islot_q <= (islot_q >= dc) ? 5'h00 : islot_q + 5'h01;
          end
        end
      end
    end
  end

  // gated transmit: shifts after each capturing fall
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_pend_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tbit_q <= 5'h00;
      tx_sh_q <= 16'h0000;
    end else if (ce) begin
      if (!port_on || !gated || !tx_on) begin
        tx_busy_q <= 1'b0;
        tbit_q <= 5'h00;
        tx_pend_q <= 1'b0;
      end else if (wr && paddr == `SSRX_A_TXDATA) begin
        tx_pend_q <= 1'b1;
        if (!master) begin
          tx_sh_q <= pwdata[15:0] << (5'h10 - wl);
        end
      end else if (master && word_edge && tx_pend_q && !tx_busy_q) begin
        tx_busy_q <= 1'b1;
        tx_pend_q <= 1'b0;
        tbit_q <= 5'h00;
        tx_sh_q <= tx_data_q << (5'h10 - wl);
      end else if (g_fall) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
        tbit_q <= (tbit_q == wl - 5'h01) ? 5'h00 : tbit_q + 5'h01;
        if (tbit_q == wl - 5'h01) begin
          tx_busy_q <= 1'b0;
          if (!master) begin
            tx_pend_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

/* sim/ssrx_port_props.sv */
`timescale 1ns/1ps
`include "ssrx_defines.vh"
module ssrx_port_props #(
  parameter QDEPTH = 8,
  parameter QAW = 3
) (
  input wire clock,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire tx_clock_pin_out,
  input wire tx_clock_pin_oe,
  input wire tx_data_pin_oe,
  input wire rx_irq
);
  // shadow of control writes, seen only at the bus pins
  logic [5:0] c2_q;
  logic [1:0] op_q;
  wire wr = psel && penable && pwrite;
  wire unm = paddr > 8'h17 || paddr[1:0] != 2'h0;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      c2_q <= 6'h00;
      op_q <= 2'h0;
    end else if (wr && paddr == `SSRX_A_CTRL2) begin
      c2_q <= pwdata[5:0];
    end else if (wr && paddr == `SSRX_A_OPTION) begin
      op_q <= pwdata[1:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  slverr_unmapped_a: assert property (psel && penable && unm |-> pslverr)
    else $error("unmapped access accepted");
  slverr_mapped_a: assert property (psel && penable && !unm |-> !pslverr)
    else $error("mapped access refused");
  rdata_unmapped_a: assert property (
    psel && !penable && !pwrite && unm |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  irq_gate_a: assert property (!op_q[1] |-> !rx_irq)
    else $error("interrupt while disabled");
  clk_oe_a: assert property (
    tx_clock_pin_oe == (c2_q[0] && c2_q[3] && c2_q[4] && !c2_q[5]))
    else $error("clock enable wrong");
  data_oe_a: assert property (
    tx_data_pin_oe == (c2_q[0] && c2_q[3] && c2_q[2] && !c2_q[5]))
    else $error("data enable wrong");
  clk_driven_a: assert property (tx_clock_pin_out |-> tx_clock_pin_oe)
    else $error("clock out while released");
  clk_high_a: assert property (
    $rose(tx_clock_pin_out) |-> ##1 tx_clock_pin_out ##1 !tx_clock_pin_out)
    else $error("clock high phase wrong");
  clk_low_a: assert property ($fell(tx_clock_pin_out) |-> ##1 !tx_clock_pin_out)
    else $error("clock low phase short");
  cover property (pslverr);
  cover property ($rose(rx_irq));
  cover property ($rose(tx_clock_pin_out));
endmodule
bind ssrx_port ssrx_port_props #(.QDEPTH(QDEPTH), .QAW(QAW)) u_props (
  .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_clock_pin_out(tx_clock_pin_out), .tx_clock_pin_oe(tx_clock_pin_oe),
  .tx_data_pin_oe(tx_data_pin_oe), .rx_irq(rx_irq));

/* sim/ssrx_codec.sv */
`timescale 1ns/1ps
module ssrx_codec (
  input wire clock,
  output logic sck,
  output logic fs,
  output logic sd,
  output logic gck
);
  logic c = 1'b0;
  logic g = 1'b0;
  initial begin
    fs = 1'b0;
    sd = 1'b0;
  end
  // one clock line toggles, the other stays low
  assign sck = c && !g;
  assign gck = c && g;
  // mode 0 framed, 1 clock without sync, 2 gated
  task automatic send(input logic [31:0] w, input int n, input int mode);
    g <= (mode == 2);
    fs <= (mode == 0);
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      sd <= w[i];
      c <= 1'b1;
      repeat (4) @(posedge clock);
      fs <= 1'b0;
      c <= 1'b0;
      repeat (4) @(posedge clock);
    end
    // released data line must not keep the last bit
    sd <= ~w[0];
  endtask
endmodule

/* sim/sync_serial_rx_gated_tb.sv */
`timescale 1ns/1ps
`include "ssrx_defines.vh"
module sync_serial_rx_gated_tb;
  localparam int QD = 8;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat, w;
  logic [31:0] q[$];
  logic pready, pslverr, rerr, sck, fs, sd, gck, ckq;
  logic txo, txoe, txd, txdoe, rx_irq;
  logic [15:0] cap;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int nr = 0;
  wire tck = txoe ? txo : gck;
  always #50 clock = ~clock;
  ssrx_codec u_codec (.clock(clock), .sck(sck), .fs(fs), .sd(sd), .gck(gck));
  ssrx_port #(.QDEPTH(QD), .QAW(3)) dut (.clock(clock), .arst_n(arst_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_clock_pin(sck),
    .rx_frame_sync_pin(fs), .rx_data_pin(sd), .tx_clock_pin_in(tck),
    .tx_clock_pin_out(txo), .tx_clock_pin_oe(txoe), .tx_data_pin_out(txd),
    .tx_data_pin_oe(txdoe), .rx_irq(rx_irq));
  function automatic int wb(int c);
    return c == 3 ? 16 : 8 + 2 * c;
  endfunction
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    ckq <= txo;
    cyc <= cyc + 1;
    if (txo && !ckq) begin
      cap <= {cap[14:0], txd};
      nr <= nr + 1;
    end
    if (cyc == 50000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic setup(input logic [31:0] rc, input logic [31:0] op, input logic [31:0] c2);
    apb(1'b1, `SSRX_A_CTRL2, 32'h0);
    apb(1'b1, `SSRX_A_RXCTRL, rc);
    apb(1'b1, `SSRX_A_OPTION, op);
    apb(1'b1, `SSRX_A_CTRL2, c2 & 32'h1);
    apb(1'b1, `SSRX_A_CTRL2, c2);
  endtask
  initial begin
    void'($urandom(32'hE40C));
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) rdchk(8'(4 * i), ALL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      setup(c, 32'h2, 32'h3);
      w = $urandom & ((32'h1 << wb(c)) - 32'h1);
      u_codec.send(w, wb(c), 1);
      rdchk(`SSRX_A_CSR, 32'h1, 32'h0);
      u_codec.send(w, wb(c), 0);
      repeat (4) @(posedge clock);
      chk(32'(rx_irq), 32'h1);
      rdchk(`SSRX_A_CSR, 32'h7, 32'h1);
      rdchk(`SSRX_A_RXDATA, ALL, w);
      rdchk(`SSRX_A_CSR, 32'h1, 32'h0);
    end
    $display("test word sizes done");
    setup(32'h4, 32'h0, 32'h3);
    w = $urandom;
    u_codec.send(w, 16, 0);
    rdchk(`SSRX_A_RXDATA, ALL, {24'h0, w[15:8]});
    u_codec.send(w, 16, 0);
    u_codec.send(~w, 16, 0);
    rdchk(`SSRX_A_CSR, 32'h5, 32'h5);
    rdchk(`SSRX_A_RXDATA, ALL, {24'h0, ~w[15:8]});
    rdchk(`SSRX_A_CSR, 32'h5, 32'h4);
    apb(1'b1, `SSRX_A_CSR, 32'h4);
    rdchk(`SSRX_A_CSR, 32'h4, 32'h0);
    $display("test overrun done");
    setup(32'h0, 32'h13, 32'h3);
    for (int i = 0; i <= QD; i++) begin
      w = $urandom & 32'hFF;
      if (i < QD) q.push_back(w);
      u_codec.send(w, 8, 0);
      repeat (4) @(posedge clock);
      if (i < 2) chk(32'(rx_irq), 32'(i));
      if (i < 2) rdchk(`SSRX_A_CSR, 32'h2, 32'(i) << 1);
    end
    rdchk(`SSRX_A_CSR, 32'hF04, (32'(QD) << 8) | 32'h4);
    while (q.size() > 0) rdchk(`SSRX_A_RXDATA, ALL, q.pop_front());
    rdchk(`SSRX_A_CSR, 32'hF02, 32'h0);
    apb(1'b1, `SSRX_A_CSR, 32'h4);
    $display("test queue done");
    setup(32'h3, 32'h0, 32'hB);
    w = $urandom & 32'hFFFF;
    u_codec.send(w, 16, 2);
    repeat (4) @(posedge clock);
    rdchk(`SSRX_A_RXDATA, ALL, w);
    rdchk(`SSRX_A_CSR, 32'h8, 32'h8);
    $display("test gated slave done");
    setup(32'h0, 32'h0, 32'h1B);
    rdchk(`SSRX_A_CSR, 32'h8, 32'h0);
    setup(32'h0, 32'h0, 32'h1D);
    w = $urandom & 32'hFF;
    nr = 0;
    apb(1'b1, `SSRX_A_TXDATA, w);
    repeat (100) @(posedge clock);
    chk(32'(nr), 32'h8);
    chk({24'h0, cap[7:0]}, w);
    apb(1'b1, `SSRX_A_CTRL2, 32'h3D);
    @(posedge clock);
    chk(32'(txoe), 32'h0);
    $display("test gated master done");
    wrap_up();
  end
endmodule
